/* rtl/hom_ctrl.sv */
// Load-side encoder homing sequencer for fully closed loop control
module hom_ctrl (
  // Clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             rst,
  // Controller commands
  input  wire logic                             home_start,
  input  wire logic [7:0]                       home_method,
  input  wire logic                             data_set_req,
  // Configuration
  input  wire logic [1:0]                       enc_type,
  input  wire logic                             alt_variant,
  input  wire logic                             mark_absent,
  input  wire logic                             soft_limit_active,
  input  wire logic                             homing_condition_select,
  input  wire logic signed [hom_pkg::POS_W-1:0] home_shift_distance_setting,
  input  wire logic [hom_pkg::POS_W-1:0]        rev_pulses,
  // Load-side encoder
  input  wire logic signed [hom_pkg::POS_W-1:0] load_pos,
  input  wire logic                             load_ref_mark,
  // Switch inputs
  input  wire logic                             dog_input,
  input  wire logic                             fwd_stroke_end_input,
  input  wire logic                             reverse_stroke_end_input,
  // Motion request to controller
  output logic                                  move_req,
  output logic                                  move_dir,
  // Homing result
  output logic                                  home_done,
  output logic                                  home_error,
  output logic signed [hom_pkg::POS_W-1:0]      home_pos,
  // Encoder zero pulse
  output logic                                  encoder_zero_pulse_output
);

  hom_pkg::hom_state_e              state_q;
  logic                             dir_q;
  logic                             reversed_q;
  logic                             mark_prev_q;
  logic                             pwr_seen_q;
  logic                             run_seen_q;
  logic signed [hom_pkg::POS_W-1:0] pwr_origin_q;
  logic                             done_q;
  logic                             err_q;
  logic signed [hom_pkg::POS_W-1:0] home_q;
  logic                             zpulse_q;
  logic                             mark_rise;
  logic                             busy;
  logic                             ready;
  logic                             start_go;
  logic                             start_bad;
  logic                             ds_go;
  logic                             stroke_hit;
  logic                             is_inc;
  logic                             is_rot;

  hom_grid_if gif ();

  // Method decoding shared by checks and direction
  function automatic logic meth_valid(input logic [7:0] m);
    return m == hom_pkg::METH_DOG || m == hom_pkg::METH_MARK_FWD ||
           m == hom_pkg::METH_MARK_REV || m == hom_pkg::METH_STROKE_FWD ||
           m == hom_pkg::METH_STROKE_REV;
  endfunction

  function automatic logic meth_stroke(input logic [7:0] m);
    return m == hom_pkg::METH_STROKE_FWD || m == hom_pkg::METH_STROKE_REV;
  endfunction

  // Paired methods share one sequence, only the direction differs
  function automatic logic meth_dir(input logic [7:0] m);
    return (m == hom_pkg::METH_MARK_REV || m == hom_pkg::METH_STROKE_REV) ?
           hom_pkg::DIR_REV : hom_pkg::DIR_FWD;
  endfunction

  // Command acceptance and shared conditions
  assign is_inc     = enc_type == hom_pkg::ENC_INC;
  assign is_rot     = enc_type == hom_pkg::ENC_ROT;
  assign busy       = state_q inside {hom_pkg::ST_TO_DOG, hom_pkg::ST_ON_DOG,
                                      hom_pkg::ST_AFTER_DOG, hom_pkg::ST_TO_MARK};
  assign ready      = !busy;
  assign start_go   = home_start && ready;
  assign ds_go      = data_set_req && ready && !home_start;
  assign start_bad  = !meth_valid(home_method) ||
                      (meth_stroke(home_method) && soft_limit_active) ||
                      (is_inc && mark_absent);
  // Mark edge: its position follows the crossing direction
  assign mark_rise  = load_ref_mark && !mark_prev_q;
  assign stroke_hit = dir_q ? fwd_stroke_end_input : reverse_stroke_end_input;

  // Grid origin: absolute zero, power-on mark, or mark after start
  // Motor encoder zero phase has no input here at all
  assign gif.load   = (start_go && !start_bad && home_method == hom_pkg::METH_DOG &&
                       (enc_type == hom_pkg::ENC_ABS ||
                        (is_inc && !alt_variant && pwr_seen_q))) ||
                      (busy && is_inc && mark_rise &&
                       (alt_variant ? !run_seen_q : !pwr_seen_q));
  assign gif.origin = start_go ? (is_inc ? pwr_origin_q : hom_pkg::ABS_ORIGIN)
                               : load_pos;
  assign gif.pos    = load_pos;
  assign gif.rev    = rev_pulses;

  hom_grid u_grid (
    .sys_clk (sys_clk),
    .rst     (rst),
    .g       (gif.grid)
  );

  // Mark history since power-on and since the last start
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mark_prev_q  <= 1'b0;
      pwr_seen_q   <= 1'b0;
      run_seen_q   <= 1'b0;
      pwr_origin_q <= hom_pkg::ABS_ORIGIN;
    end else begin
      mark_prev_q <= load_ref_mark;
      if (mark_rise && !pwr_seen_q) begin
        pwr_seen_q   <= 1'b1;
        pwr_origin_q <= load_pos;
      end
      // Set beats clear: a mark in the start cycle still counts
      if (mark_rise) begin
        run_seen_q <= 1'b1;
      end else if (start_go) begin
        run_seen_q <= 1'b0;
      end
    end
  end

  // Sequencer state and travel direction
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q    <= hom_pkg::ST_IDLE;
      dir_q      <= hom_pkg::DIR_FWD;
      reversed_q <= 1'b0;
    end else if (start_go) begin
      dir_q      <= meth_dir(home_method);
      reversed_q <= 1'b0;
      if (start_bad) begin
        state_q <= hom_pkg::ST_ERROR;
      end else if (home_method == hom_pkg::METH_DOG) begin
        state_q <= hom_pkg::ST_TO_DOG;
      end else begin
        state_q <= hom_pkg::ST_TO_MARK;
      end
    end else if (ds_go) begin
      state_q <= (pwr_seen_q || homing_condition_select) ?
                 hom_pkg::ST_DONE : hom_pkg::ST_ERROR;
    end else begin
      unique case (state_q)
        hom_pkg::ST_TO_DOG: begin
          if (stroke_hit) begin
            state_q <= hom_pkg::ST_ERROR;
          end else if (dog_input) begin
            state_q <= hom_pkg::ST_ON_DOG;
          end
        end
        hom_pkg::ST_ON_DOG: begin
          if (stroke_hit) begin
            state_q <= hom_pkg::ST_ERROR;
          end else if (!dog_input) begin
            // Incremental and rotary need a mark before the dog clears
            state_q <= (enc_type != hom_pkg::ENC_ABS && !run_seen_q && !mark_rise) ?
                       hom_pkg::ST_ERROR : hom_pkg::ST_AFTER_DOG;
          end
        end
        hom_pkg::ST_AFTER_DOG: begin
          if (is_rot ? mark_rise : gif.hit) begin
            state_q <= hom_pkg::ST_DONE;
          end else if (stroke_hit) begin
            state_q <= hom_pkg::ST_ERROR;
          end
        end
        hom_pkg::ST_TO_MARK: begin
          if (mark_rise) begin
            state_q <= hom_pkg::ST_DONE;
          end else if (stroke_hit) begin
            // Stroke methods turn once; a second end means no mark exists
            if (meth_stroke(home_method) && !reversed_q) begin
              dir_q      <= !dir_q;
              reversed_q <= 1'b1;
            end else begin
              state_q <= hom_pkg::ST_ERROR;
            end
          end
        end
        hom_pkg::ST_IDLE, hom_pkg::ST_DONE, hom_pkg::ST_ERROR: begin
          state_q <= state_q;
        end
        default: begin
          state_q <= hom_pkg::ST_ERROR;
        end
      endcase
    end
  end

  // Home position and result flags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      home_q <= hom_pkg::ABS_ORIGIN;
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else if (start_go) begin
      done_q <= 1'b0;
      err_q  <= start_bad;
    end else if (ds_go) begin
      if (pwr_seen_q || homing_condition_select) begin
        home_q <= load_pos;
        done_q <= 1'b1;
        err_q  <= 1'b0;
      end else begin
        done_q <= 1'b0;
        err_q  <= 1'b1;
      end
    end else if (state_q == hom_pkg::ST_AFTER_DOG && !is_rot && gif.hit) begin
      home_q <= gif.hit_pos;
      done_q <= 1'b1;
    end else if (state_q == hom_pkg::ST_AFTER_DOG && is_rot && mark_rise) begin
      home_q <= load_pos;
      done_q <= 1'b1;
    end else if (state_q == hom_pkg::ST_TO_MARK && mark_rise) begin
      // Rotary zero phase takes no shift
      home_q <= is_rot ? load_pos : load_pos + home_shift_distance_setting;
      done_q <= 1'b1;
    end else if (busy && !done_q) begin
      err_q <= (state_q == hom_pkg::ST_ON_DOG && !dog_input && !stroke_hit &&
                enc_type != hom_pkg::ENC_ABS && !run_seen_q && !mark_rise) ||
               (stroke_hit && !(state_q == hom_pkg::ST_TO_MARK &&
                meth_stroke(home_method) && !reversed_q));
    end
  end

  // Zero pulse out, withheld in the alternative incremental case
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      zpulse_q <= 1'b0;
    end else begin
      zpulse_q <= load_ref_mark && !(alt_variant && is_inc);
    end
  end

  assign move_req                  = busy;
  assign move_dir                  = dir_q;
  assign home_done                 = done_q;
  assign home_error                = err_q;
  assign home_pos                  = home_q;
  assign encoder_zero_pulse_output = zpulse_q;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_start_ok;
    start_go && !start_bad;
  endsequence

  sequence s_dog_clear_no_mark;
    state_q == hom_pkg::ST_ON_DOG && !dog_input && !stroke_hit &&
    enc_type != hom_pkg::ENC_ABS && !run_seen_q && !mark_rise;
  endsequence

  property p_err_not_done;
    err_q |-> !done_q;
  endproperty
  a_err_not_done: assert property (p_err_not_done) else $error("error with done");

  property p_soft_limit;
    start_go && meth_stroke(home_method) && soft_limit_active |=> err_q && !move_req;
  endproperty
  a_soft_limit: assert property (p_soft_limit) else $error("stroke method accepted");

  property p_dir_pair;
    s_start_ok |=> move_req && move_dir == meth_dir($past(home_method));
  endproperty
  a_dir_pair: assert property (p_dir_pair) else $error("wrong travel direction");

  property p_dir_stroke;
    s_start_ok ##0 home_method == hom_pkg::METH_STROKE_REV |=> move_dir == hom_pkg::DIR_REV;
  endproperty
  a_dir_stroke: assert property (p_dir_stroke) else $error("method pair direction");

  property p_shift;
    state_q == hom_pkg::ST_TO_MARK && mark_rise && !is_rot && !start_go && !ds_go |=>
      done_q && home_q == $past(load_pos) + $past(home_shift_distance_setting);
  endproperty
  a_shift: assert property (p_shift) else $error("shifted home wrong");

  property p_rot_home;
    state_q == hom_pkg::ST_AFTER_DOG && is_rot && mark_rise && !start_go && !ds_go |=>
      done_q && home_q == $past(load_pos) && !move_req;
  endproperty
  a_rot_home: assert property (p_rot_home) else $error("rotary home wrong");

  // Grid home is the candidate crossed after the dog, with no shift
  property p_grid_home;
    state_q == hom_pkg::ST_AFTER_DOG && !is_rot && gif.hit && !start_go && !ds_go |=>
      done_q && home_q == $past(gif.hit_pos);
  endproperty
  a_grid_home: assert property (p_grid_home) else $error("grid home wrong");

  // A stroke end with no turn left ends the run as a failure
  property p_mark_fail;
    state_q == hom_pkg::ST_TO_MARK && stroke_hit && !mark_rise &&
    !(meth_stroke(home_method) && !reversed_q) |=> err_q && state_q == hom_pkg::ST_ERROR;
  endproperty
  a_mark_fail: assert property (p_mark_fail) else $error("missing mark not failed");

  property p_dataset;
    ds_go && !pwr_seen_q && !homing_condition_select |=> err_q && !done_q;
  endproperty
  a_dataset: assert property (p_dataset) else $error("data set accepted");

  property p_no_mark;
    start_go && is_inc && mark_absent |=> err_q && !move_req;
  endproperty
  a_no_mark: assert property (p_no_mark) else $error("markless start accepted");

  property p_dog_mark;
    s_dog_clear_no_mark |=> err_q && state_q == hom_pkg::ST_ERROR;
  endproperty
  a_dog_mark: assert property (p_dog_mark) else $error("dog cleared without mark");

  property p_zpulse;
    alt_variant && is_inc |=> !encoder_zero_pulse_output;
  endproperty
  a_zpulse: assert property (p_zpulse) else $error("zero pulse leaked");

endmodule

/* rtl/hom_pkg.sv */
// Shared constants and types for the load-side homing block
package hom_pkg;

  // Position word width
  localparam int POS_W = 32;

  // Load-side encoder kinds
  localparam logic [1:0] ENC_ABS = 2'h0;
  localparam logic [1:0] ENC_INC = 2'h1;
  localparam logic [1:0] ENC_ROT = 2'h2;

  // Homing methods, two's complement byte
  localparam logic [7:0] METH_DOG        = 8'hff; // -1
  localparam logic [7:0] METH_MARK_FWD   = 8'h22; // 34
  localparam logic [7:0] METH_MARK_REV   = 8'h21; // 33
  localparam logic [7:0] METH_STROKE_FWD = 8'hf5; // -11
  localparam logic [7:0] METH_STROKE_REV = 8'hd5; // -43

  // Absolute encoder grid origin
  localparam logic signed [POS_W-1:0] ABS_ORIGIN = 32'h0000_0000;

  // Travel directions
  localparam logic DIR_FWD = 1'b1;
  localparam logic DIR_REV = 1'b0;

  // Homing sequencer states
  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_TO_DOG    = 3'h1,
    ST_ON_DOG    = 3'h2,
    ST_AFTER_DOG = 3'h3,
    ST_TO_MARK   = 3'h4,
    ST_DONE      = 3'h5,
    ST_ERROR     = 3'h6
  } hom_state_e;

endpackage

/* rtl/hom_grid_if.sv */
// Carrier between the homing sequencer and the candidate grid tracker
interface hom_grid_if;
  logic                                  load;
  logic signed [hom_pkg::POS_W-1:0]      origin;
  logic signed [hom_pkg::POS_W-1:0]      pos;
  logic        [hom_pkg::POS_W-1:0]      rev;
  logic                                  hit;
  logic signed [hom_pkg::POS_W-1:0]      hit_pos;

  modport ctrl (output load, output origin, output pos, output rev,
                input hit, input hit_pos);
  modport grid (input load, input origin, input pos, input rev,
                output hit, output hit_pos);
endinterface

/* rtl/hom_grid.sv */
// Candidate home grid tracker: one candidate per motor revolution
module hom_grid (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Grid link to sequencer
  hom_grid_if.grid g
);

  logic signed [hom_pkg::POS_W-1:0] lo_q;
  logic signed [hom_pkg::POS_W-1:0] hi;
  logic                             valid_q;
  logic                             settled_q;
  logic                             above;
  logic                             below;

  // Bracket edges around the current position
  assign hi    = lo_q + $signed(g.rev);
  assign above = g.pos >= hi;
  assign below = g.pos < lo_q;

  // Walk the bracket one revolution per cycle; far origins take a while
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lo_q      <= hom_pkg::ABS_ORIGIN;
      valid_q   <= 1'b0;
      settled_q <= 1'b0;
    end else if (g.load) begin
      lo_q      <= g.origin;
      valid_q   <= 1'b1;
      settled_q <= 1'b0;
    end else if (valid_q) begin
      if (above) begin
        lo_q <= hi;
      end else if (below) begin
        lo_q <= lo_q - $signed(g.rev);
      end
      settled_q <= !(above || below);
    end
  end

  // Crossing only counts once settled, so catch-up steps stay silent
  assign g.hit     = valid_q && settled_q && (above || below);
  assign g.hit_pos = above ? hi : lo_q;

endmodule

/* test/hom_load_model.sv */
// Load-side encoder, proximity dog and stroke end model facing the homing block
module hom_load_model #(
  parameter int MARK_W = 32'h4
) (
  // Clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             rst,
  // Travel request from the block
  input  wire logic                             move_req,
  input  wire logic                             move_dir,
  // Scenario setup
  input  wire logic                             set_en,
  input  wire logic signed [hom_pkg::POS_W-1:0] set_val,
  input  wire logic signed [hom_pkg::POS_W-1:0] step,
  input  wire logic signed [hom_pkg::POS_W-1:0] mark_at,
  input  wire logic signed [hom_pkg::POS_W-1:0] dog_lo,
  input  wire logic signed [hom_pkg::POS_W-1:0] dog_hi,
  input  wire logic signed [hom_pkg::POS_W-1:0] fwd_end,
  input  wire logic signed [hom_pkg::POS_W-1:0] rev_end,
  // Encoder and switch outputs
  output logic signed [hom_pkg::POS_W-1:0]      load_pos,
  output logic                                  load_ref_mark,
  output logic                                  dog_input,
  output logic                                  fwd_stroke_end_input,
  output logic                                  reverse_stroke_end_input
);
  timeunit 1ns;
  timeprecision 1ps;

  // Position moves one step per cycle while travel is requested
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      load_pos <= '0;
    end else if (set_en) begin
      load_pos <= set_val;
    end else if (move_req) begin
      load_pos <= move_dir ? load_pos + step : load_pos - step;
    end
  end

  // Mark is a window, so its rising position depends on travel direction
  assign load_ref_mark = (load_pos >= mark_at) && (load_pos < mark_at + MARK_W);
  // Dog placement chosen by the scenario
  assign dog_input = (load_pos >= dog_lo) && (load_pos <= dog_hi);
  // Stroke ends hold while beyond their limit
  assign fwd_stroke_end_input     = load_pos >= fwd_end;
  assign reverse_stroke_end_input = load_pos <= rev_end;
endmodule

/* test/testbench.sv */
// Self-checking bench for the load-side homing block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic signed [hom_pkg::POS_W-1:0] hom_pos_t;
  localparam int MARK_W = 32'h4;
  localparam hom_pos_t MK = 32'sh64, FAR = 32'sh1388, FEND = 32'sh96, REND = 32'sh32;
  localparam hom_pos_t DLO = 32'sh14, DHI = 32'sh3c;

  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       home_start = 1'b0;
  logic [7:0] home_method = 8'h00;
  logic       data_set_req = 1'b0;
  logic [1:0] enc_type = hom_pkg::ENC_ABS;
  logic       alt_variant = 1'b0, mark_absent = 1'b0, soft_limit_active = 1'b0;
  logic       homing_condition_select = 1'b0, set_en = 1'b0, prev_mark = 1'b0;
  logic       prev_gate = 1'b0, prev_rst = 1'b1;
  hom_pos_t   shift = 32'sh5, rev = 32'sh32, stp = 32'sh3, set_val = '0;
  hom_pos_t   mark_at = '0, dog_lo = '0, dog_hi = '0, fwd_end = '0, rev_end = '0;
  hom_pos_t   load_pos, home_pos;
  logic       load_ref_mark, dog_input, fwd_stroke_end_input, reverse_stroke_end_input;
  logic       move_req, move_dir, home_done, home_error, encoder_zero_pulse_output;
  int         failures = 0;
  int         n_compared = 0;

  // Free-running system clock
  always #10 sys_clk = ~sys_clk;

  hom_ctrl dut (.sys_clk(sys_clk), .rst(rst), .home_start(home_start),
    .home_method(home_method), .data_set_req(data_set_req), .enc_type(enc_type),
    .alt_variant(alt_variant), .mark_absent(mark_absent),
    .soft_limit_active(soft_limit_active), .homing_condition_select(homing_condition_select),
    .home_shift_distance_setting(shift), .rev_pulses(rev), .load_pos(load_pos),
    .load_ref_mark(load_ref_mark), .dog_input(dog_input),
    .fwd_stroke_end_input(fwd_stroke_end_input),
    .reverse_stroke_end_input(reverse_stroke_end_input), .move_req(move_req),
    .move_dir(move_dir), .home_done(home_done), .home_error(home_error),
    .home_pos(home_pos), .encoder_zero_pulse_output(encoder_zero_pulse_output));

  hom_load_model #(.MARK_W(MARK_W)) model (.sys_clk(sys_clk), .rst(rst), .move_req(move_req),
    .move_dir(move_dir), .set_en(set_en), .set_val(set_val), .step(stp), .mark_at(mark_at),
    .dog_lo(dog_lo), .dog_hi(dog_hi), .fwd_end(fwd_end), .rev_end(rev_end),
    .load_pos(load_pos), .load_ref_mark(load_ref_mark), .dog_input(dog_input),
    .fwd_stroke_end_input(fwd_stroke_end_input),
    .reverse_stroke_end_input(reverse_stroke_end_input));

  task automatic give_verdict();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input hom_pos_t exp, input hom_pos_t got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask

  // First lattice point from a start reached at or past a limit
  function automatic hom_pos_t first_at(hom_pos_t from, hom_pos_t s, hom_pos_t lim, logic fwd);
    hom_pos_t p;
    p = from;
    while (fwd ? p < lim : p > lim) p = fwd ? p + s : p - s;
    return p;
  endfunction

  // Inputs always change one nanosecond after the rising edge
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (5) tick();
    rst = 1'b0;
  endtask

  task automatic place(hom_pos_t from, hom_pos_t mk, hom_pos_t dl, hom_pos_t dh,
                       hom_pos_t fe, hom_pos_t re);
    set_en = 1'b1;
    set_val = from;
    mark_at = mk;
    dog_lo = dl;
    dog_hi = dh;
    fwd_end = fe;
    rev_end = re;
    tick();
    set_en = 1'b0;
  endtask

  // One start pulse, then a bounded wait for the outcome
  task automatic run(logic [7:0] m);
    home_start = 1'b1;
    home_method = m;
    tick();
    home_start = 1'b0;
    for (int i = 0; i < 3000; i++) begin
      if (home_done === 1'b1 || home_error === 1'b1) break;
      tick();
    end
    check("travel ended", 1'b0, move_req);
  endtask

  task automatic t_mark(logic [7:0] m, logic fwd, hom_pos_t from, hom_pos_t mk);
    hom_pos_t exp;
    place(from, mk, FAR, FAR - 1, FAR, -FAR);
    exp = first_at(from, stp, fwd ? mk : mk + MARK_W - 1, fwd);
    exp = exp + ((enc_type == hom_pkg::ENC_ROT) ? hom_pos_t'(0) : shift);
    run(m);
    check("home_done", 1'b1, home_done);
    check("home_pos", exp, home_pos);
  endtask

  task automatic t_stroke(logic [7:0] m, logic fwd, hom_pos_t from);
    hom_pos_t turn;
    place(from, MK, FAR, FAR - 1, FEND, REND);
    home_start = 1'b1;
    home_method = m;
    tick();
    check("move_dir", fwd, move_dir);
    turn = first_at(from, stp, fwd ? FEND : REND, fwd) + (fwd ? stp : -stp);
    run(m);
    check("home_pos", first_at(turn, stp, fwd ? MK + MARK_W - 1 : MK, !fwd) + shift,
          home_pos);
  endtask

  // Refused starts: stroke method under soft limit, no mark, unknown code
  task automatic t_refuse();
    logic [7:0] ms [3] = '{hom_pkg::METH_STROKE_FWD, hom_pkg::METH_MARK_FWD, 8'h00};
    for (int i = 0; i < 3; i++) begin
      soft_limit_active = (i == 0);
      mark_absent = (i == 1);
      enc_type = (i == 1) ? hom_pkg::ENC_INC : hom_pkg::ENC_ABS;
      run(ms[i]);
      check("refused error", 1'b1, home_error);
      tick();
      check("refused travel", 1'b0, move_req);
    end
    soft_limit_active = 1'b0;
    mark_absent = 1'b0;
  endtask

  // No mark ahead: mark method fails at first end, stroke method at second
  task automatic t_fail();
    logic [7:0] ms [2] = '{hom_pkg::METH_MARK_FWD, hom_pkg::METH_STROKE_FWD};
    for (int i = 0; i < 2; i++) begin
      place(32'sh78, FAR, FAR, FAR - 1, FEND, REND);
      run(ms[i]);
      check("home_error", 1'b1, home_error);
      check("home_done", 1'b0, home_done);
    end
  endtask

  task automatic t_dog(logic [1:0] enc, logic alt, hom_pos_t mk, logic ok, hom_pos_t exp);
    enc_type = enc;
    alt_variant = alt;
    place('0, mk, DLO, DHI, FAR, -FAR);
    run(hom_pkg::METH_DOG);
    check("dog done", ok, home_done);
    check("dog error", !ok, home_error);
    if (ok) check("dog home_pos", exp, home_pos);
    alt_variant = 1'b0;
  endtask

  task automatic t_data_set();
    hom_pos_t p;
    do_reset();
    place(32'sh4d, FAR, FAR, FAR - 1, FAR, -FAR);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) t_mark(hom_pkg::METH_MARK_FWD, 1'b1, 32'sh4d, MK);
      homing_condition_select = (i == 1);
      data_set_req = 1'b1;
      p = load_pos;
      tick();
      data_set_req = 1'b0;
      check("data set done", i != 0, home_done);
      check("data set error", i == 0, home_error);
      if (i != 0) check("data set pos", p, home_pos);
      tick();
    end
  endtask

  // Rotary dog: zero phase met on the dog, home at the next one after dog off
  task automatic t_rot_dog();
    place('0, 32'sh1e, DLO, DHI, FAR, -FAR);
    home_start = 1'b1;
    home_method = hom_pkg::METH_DOG;
    tick();
    home_start = 1'b0;
    repeat (15) tick();
    mark_at = 32'sh50;
    run(hom_pkg::METH_DOG);
    check("rotary dog done", 1'b1, home_done);
    check("rotary dog pos", first_at('0, stp, 32'sh50, 1'b1), home_pos);
  endtask

  // Zero pulse trails the mark by one cycle, gated in the alternative incremental variant
  always @(negedge sys_clk) begin
    if (!rst && !prev_rst) check("zero pulse", prev_mark & ~prev_gate,
                                 encoder_zero_pulse_output);
    prev_mark = load_ref_mark;
    prev_gate = alt_variant && (enc_type == hom_pkg::ENC_INC);
    prev_rst = rst;
  end

  // Watchdog at 20000 cycles, well beyond the few hundred cycles the tests need
  initial begin
    #400000;
    failures++;
    give_verdict();
  end

  initial begin
    repeat (5) tick();
    rst = 1'b0;
    t_mark(hom_pkg::METH_MARK_FWD, 1'b1, '0, MK);
    t_mark(hom_pkg::METH_MARK_REV, 1'b0, 32'shc8, MK);
    t_refuse();
    t_stroke(hom_pkg::METH_STROKE_FWD, 1'b1, 32'sh78);
    t_stroke(hom_pkg::METH_STROKE_REV, 1'b0, 32'sh50);
    t_fail();
    t_dog(hom_pkg::ENC_ABS, 1'b0, FAR, 1'b1,
          first_at(hom_pkg::ABS_ORIGIN, rev, first_at('0, stp, DHI + 1, 1'b1), 1'b1));
    do_reset();
    enc_type = hom_pkg::ENC_INC;
    t_mark(hom_pkg::METH_MARK_FWD, 1'b1, '0, 32'sha);
    t_dog(hom_pkg::ENC_INC, 1'b0, 32'sh1e, 1'b1, first_at(first_at('0, stp, 32'sha, 1'b1), rev,
          first_at('0, stp, DHI + 1, 1'b1), 1'b1));
    t_dog(hom_pkg::ENC_INC, 1'b1, 32'sh1e, 1'b1, first_at(first_at('0, stp, 32'sh1e, 1'b1), rev,
          first_at('0, stp, DHI + 1, 1'b1), 1'b1));
    t_dog(hom_pkg::ENC_INC, 1'b0, FAR, 1'b0, '0);
    enc_type = hom_pkg::ENC_ROT;
    stp = 32'sh1;
    t_mark(hom_pkg::METH_MARK_FWD, 1'b1, '0, MK);
    stp = 32'sh3;
    t_rot_dog();
    t_data_set();
    give_verdict();
  end
endmodule
